// ===== verilog/act_pkg.sv
`default_nettype none
package act_pkg;
  localparam int unsigned CLK_PERIOD_NS = 25;
  // Start-up allowance of the dedicated oscillator
  localparam int unsigned ASYNC_START_US = 5;
  localparam int unsigned ASYNC_START_CYC = (ASYNC_START_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned WARM_BUS_CYC = 3;
  localparam int unsigned SYNC_CONVERTER_CLOCK = 2;
  // 3.5 and 23.5 cycle windows, rounded up to whole converter clocks
  localparam int unsigned SAMPLE_SHORT = 4;
  localparam int unsigned SAMPLE_LONG = 24;
  localparam int unsigned T8S_FIRST = 18;
  localparam int unsigned T8S_NEXT = 16;
  localparam int unsigned T8L_FIRST = 38;
  localparam int unsigned T8L_NEXT = 36;
  localparam int unsigned T10S_FIRST = 21;
  localparam int unsigned T10S_NEXT = 19;
  localparam int unsigned T10L_FIRST = 41;
  localparam int unsigned T10L_NEXT = 39;
  localparam int unsigned STEPS_8 = 9;
  localparam int unsigned STEPS_10 = 11;
  localparam logic [4:0] CHAN_OFF = 5'h1F;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  localparam logic [4:0] CHAN_RESET = 5'h1F;
  localparam logic [1:0] DIV_RESET = 2'h0;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WARM = 3'b010,
    ST_RUN = 3'b100
  } act_state_t;
endpackage
`default_nettype wire

// ===== verilog/act_conv_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Status/control write aborts; restarts unless channel field is all ones or stop with async clock disabled is aborting.
// - Any clock configuration write aborts the running conversion.
// - Reset aborts and returns both result registers to reset values.
// - Stop entry with async clock disabled aborts the conversion.
// - Non-reset aborts leave the last completed result untouched.
// - Abort or reset drops converter power immediately, combinationally.
// - 8-bit short sample: 18 clocks plus 3 bus first, 16 later.
// - 8-bit long sample: 38 clocks plus 3 bus first, 36 later.
// - 10-bit short sample: 21 clocks plus 3 bus first, 19 later.
// - 10-bit long sample: 41 clocks plus 3 bus first, 39 later.
// - Async clock adds up to 5 us start-up to first conversion.
// - Sample window 3.5 converter clocks, or 23.5 with long sample; held as 4 or 24 whole clocks.
// - Clock source from select and async enable; ratio from divide field.
// - Approximation rounded to 8 or 10 bits, 1024 steps at 10 bits.
// - Completion loads results, sets done flag, interrupt if enabled.
// - Continuous mode starts the next conversion right after completion.
// - Divide field selects divide by 1, 2, 4 or 8.
// - Without async clock: bus clock if select high, else alternate clock.
module act_conv_ctrl (
  input wire logic I_CLK, // Bus clock
  input wire logic I_RST_N, // Async reset, active low
  input wire logic I_CE, // Clock enable
  input wire logic I_SC_WR, // Status/control write strobe
  input wire logic [4:0] I_SC_CHAN, // Channel select field
  input wire logic I_SC_CONT, // Continuous select
  input wire logic I_SC_IEN, // Done interrupt enable
  input wire logic I_CLK_WR, // Clock config write strobe
  input wire logic [1:0] I_CLK_DIV, // Clock divide field
  input wire logic I_CLK_ISEL, // Input clock select
  input wire logic I_CLK_AEN, // Async clock enable
  input wire logic I_CLK_LONG, // Long sample select
  input wire logic I_CLK_MODE10, // 10-bit mode
  input wire logic I_STOP, // Stop mode level
  input wire logic I_ALT_TICK, // Alternate clock tick
  input wire logic I_ASYNC_TICK, // Dedicated clock tick
  input wire logic I_CMP_HIGH, // Input at or above trial level
  input wire logic I_LOW_RD, // Result low read strobe
  output logic [10:0] O_DAC_TRIAL, // Trial code to the array
  output logic O_SAMPLE, // Sampling window
  output logic O_CONV_POWER, // Analog clocks and references on
  output logic [4:0] O_CHAN, // Selected channel
  output logic [1:0] O_RESULT_HIGH, // Result high bits
  output logic [7:0] O_RESULT_LOW, // Result low byte
  output logic O_DONE, // Conversion done flag
  output logic O_DONE_IRQ // Done interrupt request
);
  function automatic logic [5:0] conv_total(input logic m10, input logic lng, input logic fst);
    int unsigned t;
    t = m10 ? (lng ? (fst ? act_pkg::T10L_FIRST : act_pkg::T10L_NEXT)
                   : (fst ? act_pkg::T10S_FIRST : act_pkg::T10S_NEXT))
            : (lng ? (fst ? act_pkg::T8L_FIRST : act_pkg::T8L_NEXT)
                   : (fst ? act_pkg::T8S_FIRST : act_pkg::T8S_NEXT));
    return t[5:0];
  endfunction

  function automatic logic [2:0] div_last(input logic [1:0] d);
    return 3'((4'h1 << d) - 4'h1);
  endfunction

  function automatic logic [9:0] round_res(input logic [10:0] s, input logic m10);
    logic [11:0] r10;
    logic [9:0] r8;
    r10 = {1'b0, s} + 12'h001;
    r8 = {1'b0, s[10:2]} + 10'h001;
    if (m10) begin
      return r10[11] ? 10'h3FF : r10[10:1];
    end
    return {2'h0, (r8[9] ? 8'hFF : r8[8:1])};
  endfunction

  act_pkg::act_state_t state_q;
  logic [4:0] chan_q;
  logic cont_q, ien_q;
  logic [1:0] div_q;
  logic isel_q, aen_q, long_q, mode10_q;
  logic [7:0] warm_cnt_q;
  logic [5:0] converter_clock_cnt_q;
  logic [2:0] div_cnt_q;
  logic first_q;
  logic [10:0] sar_q;
  logic [9:0] res_q;
  logic done_q;
  logic run, stop_abort, abort, start, src_tick, converter_clock_tick, done_tick, xfer, in_steps;
  logic [5:0] total, off, slen, nsteps, step;
  logic [7:0] warm_len;
  logic [3:0] bitpos;

  assign run = (state_q == act_pkg::ST_RUN);
  assign stop_abort = I_STOP & ~aen_q;
  assign abort = I_CE & (I_SC_WR | I_CLK_WR | stop_abort);
  assign start = I_CE & I_SC_WR & (I_SC_CHAN != act_pkg::CHAN_OFF) & ~stop_abort;
  // Async tick may stall for seconds; divider only ever counts real edges
  assign src_tick = aen_q ? I_ASYNC_TICK : (isel_q ? 1'b1 : I_ALT_TICK);
  assign converter_clock_tick = I_CE & run & src_tick & (div_cnt_q == div_last(div_q));
  assign total = conv_total(mode10_q, long_q, first_q);
  assign off = first_q ? 6'(act_pkg::SYNC_CONVERTER_CLOCK) : 6'h00;
  assign slen = long_q ? 6'(act_pkg::SAMPLE_LONG) : 6'(act_pkg::SAMPLE_SHORT);
  assign nsteps = mode10_q ? 6'(act_pkg::STEPS_10) : 6'(act_pkg::STEPS_8);
  assign step = converter_clock_cnt_q - off - slen;
  assign in_steps = run & (converter_clock_cnt_q >= off + slen) & (step < nsteps);
  assign bitpos = 4'h0A - step[3:0];
  assign done_tick = converter_clock_tick & (converter_clock_cnt_q == total - 6'h01);
  assign xfer = done_tick & ~abort;
  assign warm_len = 8'(act_pkg::WARM_BUS_CYC) + (aen_q ? 8'(act_pkg::ASYNC_START_CYC) : 8'h00);

  assign O_SAMPLE = run & (converter_clock_cnt_q >= off) & (converter_clock_cnt_q < off + slen);
  assign O_DAC_TRIAL = in_steps ? (sar_q | (11'h001 << bitpos)) : sar_q;
  // Drops in the abort cycle itself, ahead of the state register
  assign O_CONV_POWER = (state_q != act_pkg::ST_IDLE) & ~abort;
  assign O_CHAN = chan_q;
  assign O_RESULT_HIGH = res_q[9:8];
  assign O_RESULT_LOW = res_q[7:0];
  assign O_DONE = done_q;
  assign O_DONE_IRQ = done_q & ien_q;

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      chan_q <= act_pkg::CHAN_RESET;
      cont_q <= 1'b0;
      ien_q <= 1'b0;
    end else if (I_CE && I_SC_WR) begin
      chan_q <= I_SC_CHAN;
      cont_q <= I_SC_CONT;
      ien_q <= I_SC_IEN;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      div_q <= act_pkg::DIV_RESET;
      isel_q <= 1'b0;
      aen_q <= 1'b0;
      long_q <= 1'b0;
      mode10_q <= 1'b0;
    end else if (I_CE && I_CLK_WR) begin
      div_q <= I_CLK_DIV;
      isel_q <= I_CLK_ISEL;
      aen_q <= I_CLK_AEN;
      long_q <= I_CLK_LONG;
      mode10_q <= I_CLK_MODE10;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      div_cnt_q <= 3'h0;
    end else if (I_CE) begin
      if (abort || !run) begin
        div_cnt_q <= 3'h0;
      end else if (src_tick) begin
        div_cnt_q <= (div_cnt_q == div_last(div_q)) ? 3'h0 : div_cnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_q <= act_pkg::ST_IDLE;
      warm_cnt_q <= 8'h00;
      converter_clock_cnt_q <= 6'h00;
      first_q <= 1'b1;
    end else if (I_CE) begin
      if (abort) begin
        state_q <= start ? act_pkg::ST_WARM : act_pkg::ST_IDLE;
        warm_cnt_q <= 8'h00;
        converter_clock_cnt_q <= 6'h00;
        first_q <= 1'b1;
      end else begin
        unique case (state_q)
          act_pkg::ST_IDLE: begin
          end
          act_pkg::ST_WARM: begin
            if (warm_cnt_q == warm_len - 8'h01) begin
              state_q <= act_pkg::ST_RUN;
              converter_clock_cnt_q <= 6'h00;
            end else begin
              warm_cnt_q <= warm_cnt_q + 8'h01;
            end
          end
          act_pkg::ST_RUN: begin
            if (done_tick) begin
              converter_clock_cnt_q <= 6'h00;
              first_q <= 1'b0;
              state_q <= cont_q ? act_pkg::ST_RUN : act_pkg::ST_IDLE;
            end else if (converter_clock_tick) begin
              converter_clock_cnt_q <= converter_clock_cnt_q + 6'h01;
            end
          end
          default: state_q <= act_pkg::ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sar_q <= 11'h000;
    end else if (I_CE) begin
      if (abort || !run || done_tick) begin
        sar_q <= 11'h000;
      end else if (converter_clock_tick && in_steps) begin
        sar_q[bitpos] <= I_CMP_HIGH;
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      res_q <= act_pkg::RESULT_RESET;
    end else if (xfer) begin
      res_q <= round_res(sar_q, mode10_q);
    end
  end

  // Set beats a low-read clear in the same cycle; a status write there aborts, so its clear wins
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      done_q <= 1'b0;
    end else if (xfer) begin
      done_q <= 1'b1;
    end else if (I_CE && (I_SC_WR || I_LOW_RD)) begin
      done_q <= 1'b0;
    end
  end

  // Assertion helper: converter clocks seen in the current conversion
  logic [5:0] ticks_q;
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ticks_q <= 6'h00;
    end else if (I_CE) begin
      if (abort || !run || done_tick) begin
        ticks_q <= 6'h00;
      end else if (converter_clock_tick) begin
        ticks_q <= ticks_q + 6'h01;
      end
    end
  end

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  sequence s_sc_write_off;
    I_CE && I_SC_WR && (I_SC_CHAN == act_pkg::CHAN_OFF);
  endsequence
  sequence s_abort_then_idle;
    ##1 (state_q == act_pkg::ST_IDLE) && !O_CONV_POWER;
  endsequence

  a_sc_write_off: assert property (s_sc_write_off |-> s_abort_then_idle)
    else $error("write with channel off did not stop converter");
  a_sc_write_start: assert property (start |=> state_q == act_pkg::ST_WARM && first_q)
    else $error("status write did not restart conversion");
  a_clk_write_abort: assert property (I_CE && I_CLK_WR && !I_SC_WR |-> s_abort_then_idle)
    else $error("clock config write did not abort");
  a_stop_abort: assert property (I_CE && I_STOP && !aen_q |=> state_q == act_pkg::ST_IDLE)
    else $error("stop entry did not abort");
  a_abort_keeps: assert property (abort |=> $stable(res_q))
    else $error("result changed on abort");
  a_power_off: assert property (abort |-> !O_CONV_POWER)
    else $error("power stayed on during abort");
  a_conv_length: assert property (xfer |-> ticks_q == total - 6'h01)
    else $error("conversion length wrong");
  a_total_bound: assert property (run |-> converter_clock_cnt_q < total)
    else $error("conversion overran its total");
  a_done_sets: assert property (xfer |=> O_DONE && (O_DONE_IRQ == ien_q))
    else $error("done flag not set on completion");
  a_cont_restart: assert property (xfer && cont_q |=> run && !first_q && converter_clock_cnt_q == 6'h00)
    else $error("continuous mode did not restart");
  a_abort_wins: assert property (done_tick && abort |=> $stable(res_q) && !run)
    else $error("completion beat abort");
endmodule // act_conv_ctrl
`default_nettype wire

// ===== verilog/act_none_placeholder_unused.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== verif/act_mux_model.sv
`timescale 1ns/1ps
`default_nettype none
// Ideal comparator behind the input multiplexer
module act_mux_model (
  input wire logic [10:0] i_trial, // Trial code
  input wire logic [10:0] i_level, // Held input, 11-bit scale
  output logic o_cmp // Input at or above trial
);
  assign o_cmp = (i_level >= i_trial);
endmodule // act_mux_model
`default_nettype wire

// ===== verif/adc_conversion_abort_timing_test.sv
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_abort_timing_test;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, sc_wr = 1'b0, clk_wr = 1'b0;
  logic cont = 1'b0, ien = 1'b0, isel = 1'b1, aen = 1'b0, lng = 1'b0, m10 = 1'b0;
  logic stop = 1'b0, alt = 1'b0, low_rd = 1'b0, cmp, samp, pwr, done, irq;
  logic [4:0] chan = 5'h03;
  logic [4:0] ochan;
  logic [1:0] dv = 2'h0;
  logic [1:0] rh;
  logic [7:0] rl;
  logic [10:0] trial;
  logic [10:0] level = 11'h000;
  logic [9:0] last_res = 10'h000;
  int failures = 0, n_tests = 0, seed = 23543;
  act_conv_ctrl uut (.I_CLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_SC_WR(sc_wr),
    .I_SC_CHAN(chan), .I_SC_CONT(cont), .I_SC_IEN(ien), .I_CLK_WR(clk_wr),
    .I_CLK_DIV(dv), .I_CLK_ISEL(isel), .I_CLK_AEN(aen), .I_CLK_LONG(lng),
    .I_CLK_MODE10(m10), .I_STOP(stop), .I_ALT_TICK(alt), .I_ASYNC_TICK(alt),
    .I_CMP_HIGH(cmp), .I_LOW_RD(low_rd), .O_DAC_TRIAL(trial), .O_SAMPLE(samp),
    .O_CONV_POWER(pwr), .O_CHAN(ochan), .O_RESULT_HIGH(rh), .O_RESULT_LOW(rl),
    .O_DONE(done), .O_DONE_IRQ(irq));
  act_mux_model u_mux (.i_trial(trial), .i_level(level), .o_cmp(cmp));
  initial begin
    forever #12.5 clk = ~clk;
  end
  // Alternate source ticks every other bus cycle
  always @(posedge clk) alt <= ~alt;
  function automatic logic [9:0] exp_res(input logic [10:0] lv, input logic md);
    int s;
    s = md ? (lv + 1) >> 1 : ((lv >> 2) + 1) >> 1;
    if (s > (md ? 1023 : 255))
      s = md ? 1023 : 255;
    return s[9:0];
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_in(input string nm, input int lo, input int hi, input int g);
    n_tests++;
    if (g < lo || g > hi) begin
      failures++;
      $display("FAIL %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  task automatic pulse_rd;
    @(posedge clk);
    low_rd <= 1'b1;
    @(posedge clk);
    low_rd <= 1'b0;
  endtask
  task automatic wr_clk(input logic [1:0] d, input logic s, input logic l, input logic m);
    @(posedge clk);
    dv <= d;
    isel <= s;
    lng <= l;
    m10 <= m;
    clk_wr <= 1'b1;
    @(posedge clk);
    clk_wr <= 1'b0;
  endtask
  task automatic wr_sc(input logic [4:0] c, input logic k);
    @(posedge clk);
    chan <= c;
    cont <= k;
    ien <= 1'($random(seed));
    level <= 11'($random(seed));
    sc_wr <= 1'b1;
    @(posedge clk);
    sc_wr <= 1'b0;
    #1;
  endtask
  task automatic wait_done(output int n, output int ns);
    n = 0;
    ns = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      if (samp === 1'b1)
        ns++;
    end while (done !== 1'b1 && n < 2000);
  endtask
  task automatic conv(input logic [1:0] d, input logic s, input logic l, input logic m);
    int n, t, f, ns;
    wr_clk(d, s, l, m);
    wr_sc(5'h05, 1'b0);
    chk("done_clear", 16'h0, done);
    chk("chan", 16'h5, ochan);
    t = m ? (l ? 41 : 21) : (l ? 38 : 18);
    f = (s ? 1 : 2) << d;
    wait_done(n, ns);
    chk_in("first_time", t * f, t * f + 8 + f, n);
    // Window of 3.5 or 23.5 clocks taken as whole converter clocks
    chk_in("sample_len", (l ? 24 : 4) * f, (l ? 24 : 4) * f, ns);
    last_res = exp_res(level, m);
    chk("result", last_res, {rh, rl});
    chk("irq", ien, irq);
    pulse_rd();
    #1;
    chk("done_read", 16'h0, done);
    chk("single_idle", 16'h0, pwr);
    $display("Test conv div %0d src %0d long %0d ten %0d done", d, s, l, m);
  endtask
  task automatic abort_by(input int k, input int w);
    wr_sc(5'h09, 1'b0);
    repeat (w) @(posedge clk);
    if (k == 0) begin
      chan <= 5'h1F;
      sc_wr <= 1'b1;
    end else if (k == 1)
      clk_wr <= 1'b1;
    else
      stop <= 1'b1;
    #1;
    chk("abort_power", 16'h0, pwr);
    @(posedge clk);
    sc_wr <= 1'b0;
    clk_wr <= 1'b0;
    repeat (60) @(posedge clk);
    stop <= 1'b0;
    #1;
    chk("abort_idle", 16'h0, pwr);
    chk("abort_done", 16'h0, done);
    chk("abort_keep", last_res, {rh, rl});
    $display("Test abort %0d done", k);
  endtask
  task automatic report_and_stop;
    $display("Compares %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #(20000 * 25);
    failures++;
    report_and_stop();
  end
  initial begin
    int n, ns;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++)
      conv(i[1:0], 1'b1, i[0], i[1]);
    conv(2'h0, 1'b0, 1'b0, 1'b0);
    for (int k = 0; k < 3; k++)
      abort_by(k, 8);
    @(posedge clk);
    aen <= 1'b1;
    stop <= 1'b1;
    wr_clk(2'h0, 1'b1, 1'b0, 1'b0);
    wr_sc(5'h04, 1'b0);
    wait_done(n, ns);
    // Dedicated clock ticks every other bus cycle; stop must not abort it
    chk_in("async_time", 18 * 2 + 3, 18 * 2 + 3 + 200, n);
    last_res = exp_res(level, 1'b0);
    chk("async_result", last_res, {rh, rl});
    @(posedge clk);
    stop <= 1'b0;
    aen <= 1'b0;
    $display("Test async done");
    wr_clk(2'h0, 1'b1, 1'b0, 1'b1);
    wr_sc(5'h07, 1'b1);
    wait_done(n, ns);
    pulse_rd();
    wait_done(n, ns);
    chk_in("next_time", 19, 19, n + 2);
    last_res = exp_res(level, 1'b1);
    chk("cont_result", last_res, {rh, rl});
    $display("Test continuous done");
    abort_by(0, 8);
    // Clock write lands in the very cycle the conversion would complete
    abort_by(1, 23);
    wr_sc(5'h0D, 1'b0);
    repeat (10) @(posedge clk);
    ce <= 1'b0;
    repeat (40) @(posedge clk);
    #1;
    chk("freeze_done", 16'h0, done);
    chk("freeze_power", 16'h1, pwr);
    @(posedge clk);
    ce <= 1'b1;
    wait_done(n, ns);
    // Frozen cycles must not count; 10 cycles ran before the freeze
    chk_in("freeze_time", 3 + 21 - 10, 3 + 21 - 10, n);
    chk("freeze_result", exp_res(level, 1'b1), {rh, rl});
    $display("Test freeze done");
    wr_sc(5'h0B, 1'b0);
    repeat (10) @(posedge clk);
    rst_n <= 1'b0;
    #1;
    chk("reset_power", 16'h0, pwr);
    chk("reset_result", 16'h0, {rh, rl});
    chk("reset_chan", 16'h1F, ochan);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("reset_idle", 16'h0, pwr);
    $display("Test reset done");
    report_and_stop();
  end
endmodule // adc_conversion_abort_timing_test
`default_nettype wire
